// ===== src/cbs_sequencer.sv
// Overview of operation
// [R1] Auto individual switch: enable, timer, phase, UV
// [R2] Host starts group mode with code, expiry
// [R3] Group mode compares every cell to shared expiry
// [R4] Timer advances one on-time per cycle
// [R5] Alive counter ticks 1 Hz, wraps after 3
// [R6] Individual exit on max expiry or UV
// [R7] Enabled fault halts switching, state fault
// [R8] Hold shutdown during run and hold extension
// [R9] Host starts emergency with code and hours
// [R10] Emergency drives all switches by phase, timer
// [R11] Emergency ignores undervoltage, measurements still allowed; here meas_en is off in emergency, so no measurement runs
// [R12] Emergency exits normally at shared expiry
// [R13] Three-bit mode field decodes eight modes
// [R14] Ten-bit expiry, unit per mode resolution
// [R15] Phase on-time is half timer resolution
// [R16] One microsecond dead time between phases
// [R17] Cycle twice on-plus-dead, plus measurement
// [R18] Measurement starts with settle delay, then acquisition
// [R19] Balancing measurements fixed at sixteen samples
// [R20] Duty field gates on-time within phase
// [R21] Host starts individual mode with code, expiries
// [R22] Duty code step adds one sixteenth
// [R23] Expiry 3FF never expires, timer wraps
// [R24] Nonzero mode write restarts timer and mode
// [R25] Even and odd alternate, never overlap
`timescale 1ns/1ps
`default_nettype none
module cbs_sequencer import cbs_pkg::*; #(
    parameter int unsigned PH_SEC_CYC = PHASE_SEC_CYC,
    parameter int unsigned PH_MIN_CYC = PHASE_MIN_CYC,
    parameter int unsigned ALIVE_TICK_CYC = ALIVE_CYC
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // Measurement engine
    input wire logic MEAS_VALID_I,
    input wire logic [3:0] MEAS_IDX_I,
    input wire logic [VOLT_W-1:0] MEAS_DATA_I,
    input wire logic MEAS_DONE_I,
    output logic MEAS_REQ_O,
    output logic [4:0] MEAS_OVSAMPLE_O,
    // Fault checks
    input wire logic FAULT_THERM_I,
    input wire logic FAULT_CAL_I,
    input wire logic FAULT_WDOG_I,
    // Switches and shutdown hold
    output logic [NCELL-1:0] CELL_SWITCH_OUT_O,
    output logic SHUTDOWN_REQUEST_HOLD_O
);
    function automatic logic is_auto(input logic [2:0] m);
        return m[2];
    endfunction : is_auto

    function automatic logic is_emerg(input logic [2:0] m);
        return m == MODE_EMERG;
    endfunction : is_emerg

    function automatic logic is_shared(input logic [2:0] m);
        return m == MODE_EMERG || m[2:1] == 2'b11;
    endfunction : is_shared

    function automatic logic is_min(input logic [2:0] m);
        return m == MODE_EMERG || m[0];
    endfunction : is_min

    function automatic logic [EXP_W-1:0] max_exp(input logic [EXP_W-1:0] e [NCELL]);
        logic [EXP_W-1:0] mx;
        mx = e[0];
        for (int i = 1; i < NCELL; i++) begin
            if (e[i] > mx) mx = e[i];
        end
        return mx;
    endfunction : max_exp

    cbs_seq_if seq ();

    // Software registers
    logic [2:0] mode_r;
    logic [1:0] msel_r;
    logic [3:0] duty_r;
    logic [1:0] hold_r;
    logic [NCELL-1:0] swen_r;
    logic [VOLT_W-1:0] uvt_r;
    logic [7:0] dly_r;
    logic [2:0] fen_r;
    logic [EXP_W-1:0] exp_r [NCELL];

    // Sequencer state
    logic [VOLT_W-1:0] cellv_r [NCELL];
    logic [NCELL-1:0] cvalid_r;
    logic [NCELL-1:0] uvdone_r;
    logic [EXP_W-1:0] timer_r;
    logic [11:0] acc_r;
    logic [1:0] act_r;
    logic [1:0] act_nxt;
    logic [1:0] alive;
    logic [NCELL-1:0] sw_nxt;

    // Decode
    logic wr_ctrl, restart, auto_m, emerg_m, uv_on, fault, expired, uv_exit, run;
    logic [EXP_W-1:0] gov_exp;
    logic [11:0] acc_sum, acc_unit;
    logic [NCELL-1:0] below, uv_ok, tmr_ok;
    logic [31:0] rd_val;
    logic [3:0] exp_idx;
    logic exp_hit;

    assign wr_ctrl = WR_I && ADDR_I == OFF_CTRL;
    assign restart = wr_ctrl && WDATA_I[CTRL_MODE_LSB +: 3] != MODE_OFF; // [R24]
    assign auto_m = is_auto(mode_r); // [R13]
    assign emerg_m = is_emerg(mode_r); // [R13]
    assign uv_on = auto_m && msel_r == MSEL_UV; // [R11]
    assign fault = |(fen_r & {FAULT_WDOG_I, FAULT_CAL_I, FAULT_THERM_I});
    assign gov_exp = is_shared(mode_r) ? exp_r[0] : max_exp(exp_r); // [R3]
    assign expired = gov_exp == EXP_RST
        || (gov_exp != EXP_FOREVER && timer_r > gov_exp); // [R23]
    assign uv_exit = uv_on && swen_r != '0 && (uvdone_r & swen_r) == swen_r; // [R6]
    assign run = (auto_m || emerg_m) && act_r != ACT_IDLE && !expired;
    assign acc_sum = acc_r + {8'h0, duty_r} + 12'h1;
    assign acc_unit = emerg_m ? UNIT_ACC_HR : UNIT_ACC_SM; // [R14]
    assign exp_idx = 4'(ADDR_I[5:2]);
    assign exp_hit = ADDR_I >= OFF_EXP0 && ADDR_I[1:0] == 2'b00
        && ADDR_I < OFF_EXP0 + 8'(4 * NCELL);

    // Phase generator hookup
    assign seq.run = run;
    assign seq.restart = restart;
    assign seq.phase_cyc = is_min(mode_r) ? PH_MIN_CYC : PH_SEC_CYC; // [R15]
    assign seq.on_cyc = (seq.phase_cyc >> 4) * ({28'h0, duty_r} + 32'h1); // [R22]
    assign seq.settle_cyc = {24'h0, dly_r} * SETTLE_STEP_CYC; // [R18]
    assign seq.meas_en = uv_on; // [R17]
    assign seq.acq_done = MEAS_DONE_I;

    cbs_phase_gen u_phase (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .seq(seq)
    );

    cbs_alive_cnt #(.TICK_CYC(ALIVE_TICK_CYC)) u_alive (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .clr_i(wr_ctrl),
        .run_i(run),
        .count_o(alive)
    );

    // Per-cell switch equations
    genvar g;
    generate
        for (g = 0; g < NCELL; g++) begin : g_cell
            logic [EXP_W-1:0] e;
            logic ph;
            assign e = is_shared(mode_r) ? exp_r[0] : exp_r[g]; // [R3]
            assign tmr_ok[g] = e != EXP_RST && (e == EXP_FOREVER || timer_r <= e); // [R23]
            assign ph = (g % 2 == 1) ? seq.even : seq.odd;
            assign below[g] = cvalid_r[g] && cellv_r[g] < uvt_r;
            assign uv_ok[g] = !uv_on || !(uvdone_r[g] || below[g]); // [R1]
            assign sw_nxt[g] = act_r == ACT_RUN && tmr_ok[g] && ph
                && (emerg_m || (auto_m && swen_r[g] && uv_ok[g])); // [R10]
        end
    endgenerate

    // Activity state
    always_comb begin
        act_nxt = act_r;
        if (wr_ctrl) begin
            act_nxt = restart ? ACT_RUN : ACT_IDLE;
        end else if (act_r == ACT_RUN && (auto_m || emerg_m)) begin
            if (fault) begin
                act_nxt = ACT_FAULT; // [R7]
            end else if (expired || uv_exit) begin
                act_nxt = ACT_NORMAL; // [R6] [R12]
            end
        end
    end

    // Register writes
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            mode_r <= MODE_RST;
            msel_r <= 2'h0;
            duty_r <= DUTY_RST;
            hold_r <= 2'h0;
            swen_r <= '0;
            uvt_r <= '0;
            dly_r <= 8'h0;
            fen_r <= 3'h0;
        end else if (WR_I) begin
            case (ADDR_I)
                OFF_CTRL: begin
                    mode_r <= WDATA_I[CTRL_MODE_LSB +: 3]; // [R13]
                    msel_r <= WDATA_I[CTRL_MSEL_LSB +: 2];
                    duty_r <= WDATA_I[CTRL_DUTY_LSB +: 4];
                    hold_r <= WDATA_I[CTRL_HOLD_LSB +: 2];
                end
                OFF_SWEN: swen_r <= WDATA_I[NCELL-1:0];
                OFF_UVT: uvt_r <= WDATA_I[VOLT_W-1:0];
                OFF_DLY: dly_r <= WDATA_I[7:0];
                OFF_FEN: fen_r <= WDATA_I[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < NCELL; i++) exp_r[i] <= EXP_RST;
        end else if (WR_I && exp_hit) begin
            exp_r[exp_idx - 4'h8] <= WDATA_I[EXP_W-1:0]; // [R14]
        end
    end

    // Latest cell results
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < NCELL; i++) cellv_r[i] <= '0;
        end else if (MEAS_VALID_I && MEAS_IDX_I < 4'(NCELL)) begin
            cellv_r[MEAS_IDX_I] <= MEAS_DATA_I;
        end
    end

    // Timer, duty accumulator, UV latches
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || wr_ctrl) begin
            timer_r <= '0; // [R24]
            acc_r <= 12'h0;
            uvdone_r <= '0;
            cvalid_r <= '0;
        end else begin
            if (seq.cycle_done && !expired) begin
                if (acc_sum >= acc_unit) begin
                    timer_r <= timer_r + 10'h1; // [R4] [R23]
                    acc_r <= acc_sum - acc_unit;
                end else begin
                    acc_r <= acc_sum; // [R20]
                end
            end
            if (MEAS_VALID_I && MEAS_IDX_I < 4'(NCELL)) begin
                cvalid_r[MEAS_IDX_I] <= 1'b1;
            end
            if (act_r == ACT_RUN && uv_on) begin
                uvdone_r <= uvdone_r | (below & swen_r); // [R6]
            end
        end
    end

    // State and outputs
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            act_r <= ACT_IDLE;
            CELL_SWITCH_OUT_O <= '0;
            SHUTDOWN_REQUEST_HOLD_O <= 1'b0;
            MEAS_OVSAMPLE_O <= OVS_FIXED;
            MEAS_REQ_O <= 1'b0;
        end else begin
            act_r <= act_nxt;
            CELL_SWITCH_OUT_O <= (act_nxt == ACT_RUN) ? sw_nxt : '0; // [R1] [R7]
            SHUTDOWN_REQUEST_HOLD_O <= run
                || (hold_r[1] && act_r != ACT_IDLE && mode_r != MODE_OFF); // [R8]
            MEAS_OVSAMPLE_O <= OVS_FIXED; // [R19]
            MEAS_REQ_O <= seq.meas_req; // [R18]
        end
    end

    // Register reads
    always_comb begin
        rd_val = 32'h0;
        if (exp_hit) begin
            rd_val = {22'h0, exp_r[exp_idx - 4'h8]};
        end else begin
            case (ADDR_I)
                OFF_CTRL: rd_val = {18'h0, hold_r, duty_r, 2'h0, msel_r, 1'b0, mode_r};
                OFF_SWEN: rd_val = {18'h0, swen_r};
                OFF_UVT: rd_val = {18'h0, uvt_r};
                OFF_DLY: rd_val = {24'h0, dly_r};
                OFF_FEN: rd_val = {29'h0, fen_r};
                OFF_STAT: rd_val = {6'h0, timer_r, 10'h0, alive, 2'h0, act_r}; // [R5]
                default: rd_val = 32'h0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            RDATA_O <= 32'h0;
        end else begin
            RDATA_O <= RD_I ? rd_val : 32'h0;
        end
    end

    chk_restart_timer: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        restart |=> timer_r == '0 && act_r == ACT_RUN) else $error("restart missed"); // [R24]
    chk_fault_halt: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (act_r == ACT_RUN && (auto_m || emerg_m) && fault && !wr_ctrl)
        |=> act_r == ACT_FAULT && CELL_SWITCH_OUT_O == '0) else $error("fault not halted"); // [R7]
    chk_normal_exit: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (act_r == ACT_RUN && emerg_m && expired && !fault && !wr_ctrl)
        |=> act_r == ACT_NORMAL) else $error("no normal exit"); // [R12]
    chk_even_parity: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (CELL_SWITCH_OUT_O & EVEN_CELL_MASK) != '0 |-> $past(seq.even))
        else $error("even cell off phase"); // [R1]
    chk_odd_parity: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (CELL_SWITCH_OUT_O & ODD_CELL_MASK) != '0 |-> $past(seq.odd))
        else $error("odd cell off phase"); // [R25]
    chk_enable_gate: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        auto_m && !wr_ctrl ##1 !$stable(swen_r) == 1'b0
        |-> (CELL_SWITCH_OUT_O & ~swen_r) == '0) else $error("disabled cell switched"); // [R1]
    chk_emerg_all: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        (emerg_m && act_r == ACT_RUN && seq.even && tmr_ok[1] && !wr_ctrl && !fault && !expired)
        |=> CELL_SWITCH_OUT_O == EVEN_CELL_MASK) else $error("emergency cells missing"); // [R10]
    chk_hold_run: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        run |=> SHUTDOWN_REQUEST_HOLD_O) else $error("shutdown hold dropped"); // [R8]
    chk_ovs_fixed: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        MEAS_REQ_O |-> MEAS_OVSAMPLE_O == 5'h10) else $error("oversample not 16"); // [R19]
endmodule : cbs_sequencer
`default_nettype wire

// ===== src/cbs_pkg.sv
package cbs_pkg;
    // Geometry
    localparam int NCELL = 14;
    localparam int EXP_W = 10;
    localparam int VOLT_W = 14;
    localparam int ADDR_W = 8;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SWEN = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_UVT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DLY = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FEN = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_EXP0 = 8'h20;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MSEL_LSB = 4;
    localparam int CTRL_DUTY_LSB = 8;
    localparam int CTRL_HOLD_LSB = 12;

    // Status register fields
    localparam int STAT_ACT_LSB = 0;
    localparam int STAT_ALIVE_LSB = 4;
    localparam int STAT_TMR_LSB = 16;

    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [3:0] DUTY_RST = 4'hf;
    localparam logic [EXP_W-1:0] EXP_RST = 10'h000;

    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_EMERG = 3'h1,
        MODE_MAN_SEC = 3'h2,
        MODE_MAN_MIN = 3'h3,
        MODE_IND_SEC = 3'h4,
        MODE_IND_MIN = 3'h5,
        MODE_GRP_SEC = 3'h6,
        MODE_GRP_MIN = 3'h7
    } cbs_mode_t;

    // Activity state codes
    localparam logic [1:0] ACT_IDLE = 2'h0;
    localparam logic [1:0] ACT_RUN = 2'h1;
    localparam logic [1:0] ACT_NORMAL = 2'h2;
    localparam logic [1:0] ACT_FAULT = 2'h3;

    localparam logic [1:0] MSEL_UV = 2'h3;
    localparam logic [EXP_W-1:0] EXP_FOREVER = 10'h3ff;
    localparam logic [4:0] OVS_FIXED = 5'h10;
    localparam logic [13:0] EVEN_CELL_MASK = 14'h2aaa;
    localparam logic [13:0] ODD_CELL_MASK = 14'h1555;

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEAD_TIME_NS = 1000;
    localparam int DEAD_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHASE_SEC_MS = 500;
    localparam int PHASE_MIN_MS = 30000;
    localparam int ALIVE_MS = 1000;
    localparam int PHASE_SEC_CYC = PHASE_SEC_MS * (CLK_HZ / 1000);
    localparam int PHASE_MIN_CYC = PHASE_MIN_MS * (CLK_HZ / 1000);
    localparam int ALIVE_CYC = ALIVE_MS * (CLK_HZ / 1000);
    localparam int SETTLE_STEP_US = 96;
    localparam int SETTLE_STEP_CYC = SETTLE_STEP_US * (CLK_HZ / 1_000_000);
    // Sixteenths of a phase window per timer unit
    localparam logic [11:0] UNIT_ACC_SM = 12'h020;
    localparam logic [11:0] UNIT_ACC_HR = 12'h780;
endpackage : cbs_pkg

// ===== src/cbs_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cbs_seq_if;
    logic run;
    logic restart;
    logic [31:0] phase_cyc;
    logic [31:0] on_cyc;
    logic [31:0] settle_cyc;
    logic meas_en;
    logic acq_done;
    logic even;
    logic odd;
    logic cycle_done;
    logic meas_req;

    modport ctl (output run, restart, phase_cyc, on_cyc, settle_cyc, meas_en, acq_done,
                 input even, odd, cycle_done, meas_req);
    modport gen (input run, restart, phase_cyc, on_cyc, settle_cyc, meas_en, acq_done,
                 output even, odd, cycle_done, meas_req);
endinterface : cbs_seq_if
`default_nettype wire

// ===== src/cbs_alive_cnt.sv
`timescale 1ns/1ps
`default_nettype none
module cbs_alive_cnt import cbs_pkg::*; #(
    parameter int unsigned TICK_CYC = ALIVE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic run_i,
    output logic [1:0] count_o
);
    logic [31:0] div_r;
    logic tick;

    assign tick = run_i && (div_r == TICK_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i || !run_i) begin
            div_r <= 32'h0;
        end else begin
            div_r <= tick ? 32'h0 : div_r + 32'h1;
        end
    end

    // Two-bit count wraps naturally after 2'b11
    always_ff @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            count_o <= 2'h0;
        end else if (tick) begin
            count_o <= count_o + 2'h1; // [R5]
        end
    end

    chk_alive_wrap: assert property (@(posedge clk_i) disable iff (rst_i || clr_i)
        (tick && count_o == 2'h3) |=> count_o == 2'h0) else $error("alive count no wrap"); // [R5]
endmodule : cbs_alive_cnt
`default_nettype wire

// ===== src/cbs_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
module cbs_phase_gen import cbs_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    cbs_seq_if.gen seq
);
    typedef enum logic [2:0] {
        PH_IDLE, PH_EVEN, PH_DEAD1, PH_ODD, PH_DEAD2, PH_SETTLE, PH_ACQ
    } cbs_phase_t;

    cbs_phase_t state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic done_nxt, req_nxt;
    logic win_end, dead_end;

    assign win_end = cnt_r == seq.phase_cyc - 32'h1;
    assign dead_end = cnt_r == DEAD_CYC - 1;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 32'h1;
        done_nxt = 1'b0;
        req_nxt = 1'b0;
        case (state_r)
            PH_IDLE: begin
                cnt_nxt = 32'h0;
                if (seq.run) state_nxt = PH_EVEN;
            end
            PH_EVEN: if (win_end) begin
                state_nxt = PH_DEAD1; // [R25]
                cnt_nxt = 32'h0;
            end
            PH_DEAD1: if (dead_end) begin
                state_nxt = PH_ODD; // [R16]
                cnt_nxt = 32'h0;
            end
            PH_ODD: if (win_end) begin
                state_nxt = PH_DEAD2;
                cnt_nxt = 32'h0;
            end
            PH_DEAD2: if (dead_end) begin
                cnt_nxt = 32'h0;
                if (seq.meas_en) begin
                    state_nxt = PH_SETTLE; // [R17]
                end else begin
                    state_nxt = PH_EVEN;
                    done_nxt = 1'b1;
                end
            end
            PH_SETTLE: if (cnt_r >= seq.settle_cyc) begin
                state_nxt = PH_ACQ; // [R18]
                req_nxt = 1'b1;
                cnt_nxt = 32'h0;
            end
            PH_ACQ: begin
                cnt_nxt = 32'h0;
                if (seq.acq_done) begin
                    state_nxt = PH_EVEN;
                    done_nxt = 1'b1;
                end
            end
            default: state_nxt = PH_IDLE;
        endcase
        if (!seq.run || seq.restart) begin
            state_nxt = PH_IDLE;
            cnt_nxt = 32'h0;
            done_nxt = 1'b0;
            req_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= PH_IDLE;
            cnt_r <= 32'h0;
            seq.even <= 1'b0;
            seq.odd <= 1'b0;
            seq.cycle_done <= 1'b0;
            seq.meas_req <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            seq.even <= state_r == PH_EVEN && cnt_r < seq.on_cyc; // [R20]
            seq.odd <= state_r == PH_ODD && cnt_r < seq.on_cyc; // [R20]
            seq.cycle_done <= done_nxt; // [R4]
            seq.meas_req <= req_nxt;
        end
    end

    chk_phase_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(seq.even && seq.odd)) else $error("even and odd overlap"); // [R25]
    chk_dead_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(seq.even) |-> !seq.odd [*8]) else $error("odd too soon after even"); // [R16]
endmodule : cbs_phase_gen
`default_nettype wire

// ===== verification/cbs_cell_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbs_cell_model import cbs_pkg::*; (
    // Link to the sequencer
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [NCELL-1:0] sw_i,
    // Measurement answers
    output logic valid_o,
    output logic [3:0] idx_o,
    output logic [VOLT_W-1:0] data_o,
    output logic done_o
);
    int volt[NCELL];
    int cnt = -1;
    initial begin
        valid_o = 1'b0;
        idx_o = 4'h0;
        data_o = 14'h0;
        done_o = 1'b0;
        foreach (volt[i]) volt[i] = 'h3000;
    end
    always @(posedge clk_i) begin
        foreach (volt[i]) if (sw_i[i]) volt[i] = volt[i] - 1;
        valid_o <= 1'b0;
        done_o <= 1'b0;
        // Released data lines toggle so no stale value survives
        data_o <= ~data_o;
        if (req_i) begin
            cnt = 0;
        end else if (cnt >= 0 && cnt < NCELL) begin
            valid_o <= 1'b1;
            idx_o <= 4'(cnt);
            data_o <= VOLT_W'(volt[cnt]);
            cnt++;
        end else if (cnt == NCELL) begin
            done_o <= 1'b1;
            cnt = -1;
        end
    end
endmodule : cbs_cell_model
`default_nettype wire

// ===== verification/cbs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, g) chk(nm, 32'(e), 32'(g))
module cbs_sequencer_tb import cbs_pkg::*;;
    logic clk, rst, wr, rd, fth, fca, fwd, mv, md, mreq, hold, clr, mseen;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] midx;
    logic [VOLT_W-1:0] mdat;
    logic [4:0] ovs;
    logic [NCELL-1:0] sw, seen, m_swen = '0, m_allow, m_q, m_qq;
    // Shadow of the written settings for the switch model
    int m_mode = 0;
    int m_exp[NCELL];
    int n_mismatch = 0;
    int comparisons = 0;
    cbs_sequencer #(.PH_SEC_CYC(64), .PH_MIN_CYC(128), .ALIVE_TICK_CYC(50)) dut (
        .REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .MEAS_VALID_I(mv), .MEAS_IDX_I(midx),
        .MEAS_DATA_I(mdat), .MEAS_DONE_I(md), .MEAS_REQ_O(mreq),
        .MEAS_OVSAMPLE_O(ovs), .FAULT_THERM_I(fth), .FAULT_CAL_I(fca),
        .FAULT_WDOG_I(fwd), .CELL_SWITCH_OUT_O(sw), .SHUTDOWN_REQUEST_HOLD_O(hold));
    cbs_cell_model far (.clk_i(clk), .req_i(mreq), .sw_i(sw), .valid_o(mv),
        .idx_o(midx), .data_o(mdat), .done_o(md));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_reg(logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == OFF_CTRL) m_mode = v[2:0];
        if (a == OFF_SWEN) m_swen = v[NCELL-1:0];
        if (a >= OFF_EXP0 && a < OFF_EXP0 + 8'(4 * NCELL)) begin
            m_exp[(a - OFF_EXP0) / 4] = v[EXP_W-1:0];
        end
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic wait_act(logic [1:0] e, int n);
        logic [31:0] v;
        repeat (n) begin
            rd_reg(OFF_STAT, v);
            if (v[1:0] === e) break;
        end
        `CK("activity", e, v[1:0]);
    endtask : wait_act
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    // Cells the mode may switch at all
    always_comb begin
        m_allow = '0;
        for (int i = 0; i < NCELL; i++) begin
            if (m_mode == 1 || (m_mode >= 4 && m_swen[i]
                && m_exp[(m_mode >= 6) ? 0 : i] != 0)) begin
                m_allow[i] = 1'b1;
            end
        end
    end
    always @(posedge clk) begin
        seen <= clr ? '0 : (seen | sw);
        mseen <= rst ? 1'b0 : (mseen | mreq);
        // Switches lag a settings write by up to two cycles
        m_q <= m_allow;
        m_qq <= m_q;
        if (!rst) begin
            `CK("overlap", 0, (|(sw & EVEN_CELL_MASK)) & (|(sw & ODD_CELL_MASK)));
            `CK("switch model", 0, sw & ~(m_allow | m_q | m_qq));
        end
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        logic [31:0] d;
        logic [13:0] en;
        void'($urandom(32'h790b4db0));
        {rst, clr} = 2'b11;
        {wr, rd, fth, fca, fwd} = '0;
        addr = '0;
        wdata = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(OFF_CTRL, d);
        `CK("ctrl reset", 32'h0f00, d);
        `CK("oversample", 5'h10, ovs);
        rd_reg(8'hfc, d);
        `CK("unmapped", 0, d);
        wr_reg(OFF_EXP0, 32'h3ff);
        for (int m = 0; m < 8; m++) begin
            wr_reg(OFF_CTRL, 32'h0f00 | m);
            rd_reg(OFF_STAT, d);
            `CK("mode status", (m != 0) ? 1 : 0, d);
        end
        // Emergency run, undervoltage armed but ignored
        en = 14'($urandom);
        wr_reg(OFF_SWEN, 32'(en));
        wr_reg(OFF_UVT, 32'h3fff);
        wr_reg(OFF_CTRL, 32'h0f31);
        clr <= 1'b0;
        repeat (24) @(posedge clk);
        for (int k = 0; k < 6; k++) begin
            rd_reg(OFF_STAT, d);
            `CK("alive", k % 4, d[5:4]);
            repeat (48) @(posedge clk);
        end
        repeat (500) @(posedge clk);
        `CK("emergency switches", 14'h3fff, seen);
        `CK("hold", 1, hold);
        wait_act(ACT_RUN, 1);
        // Individual run: cell one for two units, cell two for one
        for (int n = 0; n < NCELL; n++) begin
            wr_reg(OFF_EXP0 + 8'(4 * n), (n < 2) ? 2 - n : 0);
        end
        wr_reg(OFF_SWEN, 32'h3);
        wr_reg(OFF_CTRL, 32'h0f04);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wait_act(ACT_NORMAL, 2000);
        `CK("individual switches", 14'h3, seen);
        `CK("off after exit", 0, sw);
        // Group run: every cell against the shared expiry
        wr_reg(OFF_EXP0, 32'h1);
        wr_reg(OFF_SWEN, 32'h3fff);
        wr_reg(OFF_CTRL, 32'h0f06);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wait_act(ACT_NORMAL, 2000);
        `CK("group switches", 14'h3fff, seen);
        `CK("no measure", 0, mseen);
        // Undervoltage alone ends an individual run, timer never expires
        wr_reg(OFF_EXP0, 32'h3ff);
        wr_reg(OFF_CTRL, 32'h0f34);
        wait_act(ACT_NORMAL, 300);
        `CK("measure request", 1, mseen);
        `CK("uv switches", 0, sw);
        // Thermal fault in mid-run
        wr_reg(OFF_EXP0, 32'h3ff);
        wr_reg(OFF_FEN, 32'h1);
        wr_reg(OFF_CTRL, 32'h0f04);
        repeat (400) @(posedge clk);
        fth <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CK("fault switches", 0, sw);
        wait_act(ACT_FAULT, 2);
        fth <= 1'b0;
        end_of_test();
    end
endmodule : cbs_sequencer_tb
`default_nettype wire
